/* File: include/compat_defs.vh */
`ifndef COMPAT_DEFS_VH
`define COMPAT_DEFS_VH

// ---------------------------------------------------------------
// exception vectors
// ---------------------------------------------------------------
`define VEC_INVALID_OPCODE     8'h06
`define VEC_GENERAL_PROT       8'h0D

// ---------------------------------------------------------------
// address formation and limits
// ---------------------------------------------------------------
`define SEG_SHIFT              4
`define OFFSET_LIMIT           32'h0000FFFF
`define BITMAP_PTR_OFFSET      32'h00000066
`define BITMAP_PTR_MAX         16'hDFFF
`define COMPAT_CPL             2'h3

// ---------------------------------------------------------------
// flags image field positions
// ---------------------------------------------------------------
`define FLAG_TF_BIT            8
`define FLAG_IF_BIT            9
`define FLAG_MODE_BIT          17

// ---------------------------------------------------------------
// instruction class codes from the decoder
// ---------------------------------------------------------------
`define CLS_NONE               5'h00
`define CLS_PRIV               5'h01
`define CLS_PROT_ONLY          5'h02
`define CLS_INT_N              5'h03
`define CLS_INT3               5'h04
`define CLS_INTO               5'h05
`define CLS_BOUND              5'h06
`define CLS_STI                5'h07
`define CLS_CLI                5'h08
`define CLS_PUSH_FLAGS_INSTR              5'h09
`define CLS_POP_FLAGS_INSTR               5'h0A
`define CLS_INTERRUPT_RETURN_INSTR               5'h0B
`define CLS_IO                 5'h0C
`define CLS_MEM                5'h0D

// ---------------------------------------------------------------
// state machine codes, one-hot
// ---------------------------------------------------------------
`define ST_IDLE                5'b00001
`define ST_PTR_RD              5'b00010
`define ST_MAP_RD              5'b00100
`define ST_CHECK               5'b01000
`define ST_DONE                5'b10000

`endif

/* File: hdl/io_bitmap_check.v */
`timescale 1ns/100ps
`include "compat_defs.vh"

// checks the permission bits covering one port access against bitmap word
module io_bitmap_check (
  // access
  input  wire [15:0] port_addr,
  input  wire [2:0]  access_size,
  input  wire [15:0] map_word,
  // answer
  output reg         allowed
);

  integer i;
  reg [3:0] mask;
  reg [4:0] pos;

  // all bits for the addressed bytes must be zero
  always @* begin
    mask    = 4'h0;
    pos     = 5'h00;
    allowed = 1'b1;
    case (access_size)
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h4:    mask = 4'hF;
      default: mask = 4'hF;
    endcase
    for (i = 0; i < 4; i = i + 1) begin
      pos = {2'b00, port_addr[2:0]} + i[4:0];
      if (mask[i] && map_word[pos[3:0]]) begin
        allowed = 1'b0;
      end
    end
  end

endmodule

/* File: hdl/compat_mode_protection_checker.v */
`timescale 1ns/100ps
`include "compat_defs.vh"

module compat_mode_protection_checker (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // decoded instruction
  input  wire        instr_valid,
  input  wire [4:0]  instr_class,
  input  wire        protected_mode,
  input  wire [1:0]  prot_privilege,
  input  wire [1:0]  io_privilege_level,
  input  wire [15:0] segment_value,
  input  wire [31:0] eff_offset,
  input  wire [15:0] io_port,
  input  wire [2:0]  io_size,
  // task state segment
  input  wire [31:0] tss_base,
  input  wire [31:0] tss_limit,
  // memory read port for task state segment
  output reg         mem_rd_req,
  output reg  [31:0] mem_rd_addr,
  input  wire        mem_rd_ack,
  input  wire [15:0] mem_rd_data,
  // flags traffic
  input  wire [31:0] flags_in,
  input  wire [31:0] stacked_flags,
  input  wire        interrupt_return_instr_32bit,
  output reg  [31:0] push_flags_data,
  // mode transitions
  input  wire        int_event,
  input  wire        gate_is_interrupt,
  input  wire        target_conforming,
  input  wire [1:0]  target_dpl,
  input  wire [15:0] target_selector,
  input  wire        task_switch,
  input  wire [31:0] task_flags_image,
  input  wire [31:0] task_page_dir,
  // results
  output reg         compat_mode_flag,
  output wire [1:0]  current_privilege_level,
  output reg  [31:0] linear_addr,
  output reg         check_done,
  output reg         fault,
  output reg  [7:0]  fault_vector,
  output reg  [15:0] fault_error_code,
  output reg  [31:0] saved_flags,
  output reg         clear_tf,
  output reg         clear_if,
  output reg  [31:0] page_directory_base_reg
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // the decoder hands over one class code per instruction; this block never
  // sees opcodes, so every class below is a decoder promise, not a decode here.
  // classes that this block treats as privileged, protected-only, io level
  // sensitive or exempt all arrive on instr_class with instr_valid high.
  //
  // io level sensitivity differs between the two modes:
  //   - set and clear interrupt enable are sensitive in both modes
  //   - software interrupt, push flags, pop flags and interrupt return are
  //     sensitive in compat mode only, so a monitor can virtualise the
  //     interrupt enable flag for the guest
  //   - port input and output are sensitive outside compat mode only; in
  //     compat mode they are judged by the task bitmap instead
  //   - breakpoint interrupt, overflow trap and bounds check never are
  //
  // a hazard for users: a class code outside the table falls to the default
  // branch and is treated as not sensitive, so an unknown class never takes an io level trap

  // instructions checked against io privilege in the current mode
  function io_privilege_level_sensitive;
    input [4:0] cls;
    input       vm;
    begin
      case (cls)
        `CLS_STI, `CLS_CLI: io_privilege_level_sensitive = 1'b1;
        `CLS_INT_N, `CLS_PUSH_FLAGS_INSTR, `CLS_POP_FLAGS_INSTR, `CLS_INTERRUPT_RETURN_INSTR:
          io_privilege_level_sensitive = vm;
        `CLS_IO: io_privilege_level_sensitive = ~vm;
        default: io_privilege_level_sensitive = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // privilege and address
  // ---------------------------------------------------------------
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [15:0] map_ptr_reg;
  reg  [31:0] map_addr_reg;
  wire        port_allowed;
  wire [31:0] map_byte_off;
  wire [32:0] map_end;

  // compat mode always runs at the least privilege
  assign current_privilege_level = compat_mode_flag ? `COMPAT_CPL : prot_privilege;

  // the bitmap holds one bit per byte-wide port, eight ports to a byte; the
  // byte holding the first addressed port sits at pointer plus port over 8.
  // a word access starting at port 7 of a byte, or a dword access starting at
  // port 5, 6 or 7 of a byte, needs bits from the following byte too, so
  // the fetch is always a 16-bit word and the limit test uses the second byte.
  // the price is that a single-byte access to the very last byte of a segment
  // is refused; supervisor software keeps an all-ones byte after the map
  // inside the limit, so that case never guards a real port anyway.

  // bitmap byte offset covering the first port; read a word to span two bytes
  assign map_byte_off = {16'h0000, map_ptr_reg} + {19'h00000, io_port[15:3]};
  assign map_end      = {1'b0, map_byte_off} + 33'h000000001;

  io_bitmap_check u_check (
    .port_addr   (io_port),
    .access_size (io_size),
    .map_word    (mem_rd_data),
    .allowed     (port_allowed)
  );

  // ---------------------------------------------------------------
  // bitmap fetch state machine
  // ---------------------------------------------------------------
  // walk of one compat mode port access:
  //   idle    : port class seen with instr_valid, move to pointer read
  //   ptr_rd  : request the pointer word at task base plus 66H, hold the
  //             request until the memory side acknowledges
  //   map_rd  : one quiet cycle; the pointer is now in map_ptr_reg and the
  //             absolute map address is latched from it
  //   check   : if the second byte of the word lies beyond the limit, answer at once
  //             with a fault; otherwise request the map word until acked
  //   done    : one cycle so the next instruction starts from a clean idle
  // instr_valid is ignored outside idle; the decoder must wait for
  // check_done and one further cycle before it issues again.
  // the quiet cycle in map_rd keeps the latched pointer and the adder that
  // forms the map address off the memory read path in one clock.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_IDLE:
        if (instr_valid && compat_mode_flag && instr_class == `CLS_IO)
          state_next = `ST_PTR_RD;
      `ST_PTR_RD:
        if (mem_rd_ack)
          state_next = `ST_MAP_RD;
      `ST_MAP_RD:
        state_next = `ST_CHECK;
      `ST_CHECK:
        if (map_end[31:0] > tss_limit || map_end[32])
          state_next = `ST_DONE;
        else if (mem_rd_ack)
          state_next = `ST_DONE;
      `ST_DONE:
        state_next = `ST_IDLE;
      default:
        state_next = `ST_IDLE;
    endcase
  end

  // memory request address per state; the request is a level that stands
  // from the first cycle of a read state until the acknowledge is sampled,
  // and the address does not move while it stands

  // memory request address per state
  always @* begin
    mem_rd_req  = 1'b0;
    mem_rd_addr = 32'h00000000;
    case (state_reg)
      `ST_PTR_RD: begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = tss_base + `BITMAP_PTR_OFFSET;
      end
      `ST_CHECK: begin
        mem_rd_req  = ~(map_end[31:0] > tss_limit || map_end[32]);
        mem_rd_addr = map_addr_reg;
      end
      default: begin
        mem_rd_req  = 1'b0;
        mem_rd_addr = 32'h00000000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // main sequential logic
  // ---------------------------------------------------------------
  // check_done, fault, clear_tf and clear_if are one-cycle pulses and fall
  // back to zero on every edge unless something below raises them.
  // fault_vector, fault_error_code and linear_addr stand until the next
  // verdict overwrites them, so the core may read them late.
  //
  // fault priority for single-cycle checks, highest first:
  //   1. protected-only class outside protected mode or in compat mode, vector 6
  //   2. privileged class at any level above 0, vector 13
  //   3. io level sensitive class above the io level, vector 13
  //   4. compat mode offset beyond 64 Kbyte, vector 13
  // only an instruction that passes all four may touch flags state.
  //
  // an interrupt and a task switch in the same cycle: the task switch is
  // written last and so decides the mode flag; the interrupt still saves
  // its flags image and pulses its clears.
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg               <= `ST_IDLE;
      map_ptr_reg             <= 16'h0000;
      map_addr_reg            <= 32'h00000000;
      compat_mode_flag        <= 1'b0;
      linear_addr             <= 32'h00000000;
      check_done              <= 1'b0;
      fault                   <= 1'b0;
      fault_vector            <= 8'h00;
      fault_error_code        <= 16'h0000;
      saved_flags             <= 32'h00000000;
      clear_tf                <= 1'b0;
      clear_if                <= 1'b0;
      push_flags_data         <= 32'h00000000;
      page_directory_base_reg <= 32'h00000000;
    end else begin
      state_reg  <= state_next;
      check_done <= 1'b0;
      fault      <= 1'b0;
      clear_tf   <= 1'b0;
      clear_if   <= 1'b0;

      // pointer arrives, remember bitmap location
      if (state_reg == `ST_PTR_RD && mem_rd_ack) begin
        map_ptr_reg <= mem_rd_data;
      end
      if (state_reg == `ST_MAP_RD) begin
        map_addr_reg <= tss_base + map_byte_off;
      end

      // bitmap verdict
      if (state_reg == `ST_CHECK) begin
        if (map_end[31:0] > tss_limit || map_end[32]) begin
          check_done   <= 1'b1;
          fault        <= 1'b1;
          fault_vector <= `VEC_GENERAL_PROT;
        end else if (mem_rd_ack) begin
          check_done   <= 1'b1;
          fault        <= ~port_allowed;
          fault_vector <= `VEC_GENERAL_PROT;
        end
      end

      // single-cycle checks for everything else
      if (state_reg == `ST_IDLE && instr_valid &&
          !(compat_mode_flag && instr_class == `CLS_IO)) begin
        check_done       <= 1'b1;
        fault_error_code <= 16'h0000;
        if (compat_mode_flag)
          linear_addr <= ({16'h0000, segment_value} << `SEG_SHIFT) + eff_offset;
        else
          linear_addr <= eff_offset;
        if (instr_class == `CLS_PROT_ONLY && (!protected_mode || compat_mode_flag)) begin
          fault        <= 1'b1;
          fault_vector <= `VEC_INVALID_OPCODE;
        end else if (instr_class == `CLS_PRIV && current_privilege_level != 2'h0) begin
          fault        <= 1'b1;
          fault_vector <= `VEC_GENERAL_PROT;
        end else if (io_privilege_level_sensitive(instr_class, compat_mode_flag) &&
                     current_privilege_level > io_privilege_level) begin
          fault        <= 1'b1;
          fault_vector <= `VEC_GENERAL_PROT;
        end else if (compat_mode_flag && eff_offset > `OFFSET_LIMIT) begin
          fault        <= 1'b1;
          fault_vector <= `VEC_GENERAL_PROT;
        end else begin
          if (instr_class == `CLS_PUSH_FLAGS_INSTR) begin
            push_flags_data <= flags_in & ~(32'h00000001 << `FLAG_MODE_BIT);
          end
          // pop flags never touches the mode flag
          if (instr_class == `CLS_INTERRUPT_RETURN_INSTR && protected_mode && !compat_mode_flag &&
              interrupt_return_instr_32bit && current_privilege_level == 2'h0) begin
            compat_mode_flag <= stacked_flags[`FLAG_MODE_BIT];
          end
        end
      end

      // leaving compat mode: the live mode flag clears but the saved image
      // keeps the bit set, so the level 0 handler can tell where it came from
      // and the matching return can restore the mode. a gate into a
      // conforming or nonzero level segment cannot carry that return, so it
      // faults with the target selector as the error code.
      // interrupt out of compat mode
      if (int_event && compat_mode_flag) begin
        saved_flags      <= flags_in | (32'h00000001 << `FLAG_MODE_BIT);
        if (target_conforming || target_dpl != 2'h0) begin
          fault            <= 1'b1;
          fault_vector     <= `VEC_GENERAL_PROT;
          fault_error_code <= target_selector;
        end
        compat_mode_flag <= 1'b0;
        clear_tf         <= 1'b1;
        clear_if         <= gate_is_interrupt;
      end

      // a task switch may enter compat mode from any level; it also swaps
      // the page mapping so that each compat task may see its own memory
      // task switch reloads mode and page mapping
      if (task_switch) begin
        compat_mode_flag        <= task_flags_image[`FLAG_MODE_BIT];
        page_directory_base_reg <= task_page_dir;
      end
    end
  end

endmodule

/* File: verif/compat_checker_asserts.sv */
`timescale 1ns/100ps
`include "compat_defs.vh"

// ----------------------------------------
// compat mode protection checker
// ----------------------------------------
module compat_checker_asserts (
  // clock and reset
  input wire        clk_sys, nrst,
  // decoded instruction
  input wire        instr_valid, protected_mode, interrupt_return_instr_32bit,
  input wire [4:0]  instr_class,
  input wire [1:0]  prot_privilege, io_privilege_level, target_dpl,
  input wire [15:0] segment_value, target_selector,
  input wire [31:0] eff_offset, tss_base, task_page_dir, mem_rd_addr,
  // events and results
  input wire        int_event, gate_is_interrupt, target_conforming, task_switch,
  input wire        mem_rd_req, compat_mode_flag, fault, clear_tf, clear_if,
  input wire [1:0]  current_privilege_level,
  input wire [7:0]  fault_vector,
  input wire [15:0] fault_error_code,
  input wire [31:0] push_flags_data, linear_addr, saved_flags, page_directory_base_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // instruction taken while running in compat mode
  wire compat_issue = instr_valid && compat_mode_flag;

  chk_cpl_forced: assert property (compat_mode_flag |-> current_privilege_level == 2'h3)
    else $error("privilege not forced to 3 in compat mode");
  chk_linear_form: assert property (compat_issue && instr_class == `CLS_MEM |=>
    linear_addr == {12'h0, $past(segment_value), 4'h0} + $past(eff_offset))
    else $error("linear address not segment times 16 plus offset");
  chk_offset_limit: assert property (compat_issue && instr_class == `CLS_MEM &&
    eff_offset > 32'h0000FFFF |=> fault && fault_vector == 8'h0D)
    else $error("offset beyond 64 Kbyte not trapped");
  chk_priv_trap: assert property (instr_valid && instr_class == `CLS_PRIV &&
    (compat_mode_flag || protected_mode && prot_privilege != 2'h0) |=> fault && fault_vector == 8'h0D)
    else $error("privileged instruction not trapped");
  chk_prot_only: assert property (instr_valid && instr_class == `CLS_PROT_ONLY &&
    (!protected_mode || compat_mode_flag) |=> fault && fault_vector == 8'h06)
    else $error("protected-only instruction not invalid");
  chk_io_privilege_level_trap: assert property (compat_issue && io_privilege_level != 2'h3 &&
    instr_class inside {`CLS_INT_N, `CLS_STI, `CLS_CLI, `CLS_PUSH_FLAGS_INSTR, `CLS_POP_FLAGS_INSTR, `CLS_INTERRUPT_RETURN_INSTR}
    |=> fault && fault_vector == 8'h0D)
    else $error("io level sensitive instruction not trapped");
  chk_exempt_pass: assert property (instr_valid && eff_offset <= 32'h0000FFFF &&
    instr_class inside {`CLS_INT3, `CLS_INTO, `CLS_BOUND} |=> !fault)
    else $error("exempt instruction faulted");
  chk_bitmap_ptr: assert property (compat_issue && instr_class == `CLS_IO |=>
    mem_rd_req && mem_rd_addr == $past(tss_base) + 32'h00000066)
    else $error("port access did not fetch bitmap pointer");
  chk_int_exit: assert property (int_event && compat_mode_flag && !task_switch |=>
    !compat_mode_flag && saved_flags[17] && clear_tf && clear_if == $past(gate_is_interrupt))
    else $error("interrupt exit from compat mode wrong");
  chk_gate_fault: assert property (int_event && compat_mode_flag && !task_switch &&
    (target_conforming || target_dpl != 2'h0) |=> fault && fault_error_code == $past(target_selector))
    else $error("bad gate target not faulted with selector");
  chk_dir_reload: assert property (task_switch |=>
    page_directory_base_reg == $past(task_page_dir))
    else $error("page directory base not reloaded");
  chk_push_zero: assert property (!push_flags_data[17])
    else $error("pushed image carries mode bit");
  chk_mode_entry: assert property ($rose(compat_mode_flag) |-> $past(task_switch) ||
    $past(instr_valid) && $past(instr_class) == `CLS_INTERRUPT_RETURN_INSTR && $past(prot_privilege) == 2'h0 &&
    $past(interrupt_return_instr_32bit))
    else $error("compat mode entered by illegal path");

  cover property (compat_issue && instr_class == `CLS_IO);
  cover property (int_event && compat_mode_flag);
  cover property ($rose(compat_mode_flag));
endmodule

bind compat_mode_protection_checker compat_checker_asserts compat_checker_asserts_inst (.*);

/* File: verif/tss_memory_model.sv */
`timescale 1ns/100ps

// ----------------------------------------
// task state segment memory
// ----------------------------------------
module tss_memory_model (
  // clock and pacing
  input  wire        clk_sys,
  input  wire        slow,
  // read port
  input  wire        mem_rd_req,
  input  wire [31:0] mem_rd_addr,
  output reg         mem_rd_ack,
  output reg  [15:0] mem_rd_data
);
  reg     [7:0] mem [0:255];
  reg     [1:0] wait_cnt;
  integer       i;

  // pointer 68H well below DFFFH, sparse map, all-ones byte after the map
  initial begin
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'hFF;
    for (i = 8'h68; i < 8'h88; i = i + 1)
      mem[i] = i[7:0] & {i[3:0], i[7:4]};
    mem[8'h66] = 8'h68;
    mem[8'h67] = 8'h00;
    mem_rd_ack = 1'b0;
    mem_rd_data = 16'h0000;
    wait_cnt = 2'h0;
  end

  // one-cycle acknowledge, prompt or after three waits; data scrambled when idle
  always @(posedge clk_sys) begin
    if (mem_rd_ack) begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
    end else if (mem_rd_req && (!slow || wait_cnt == 2'h3)) begin
      mem_rd_ack <= 1'b1;
      mem_rd_data <= {mem[mem_rd_addr[7:0] + 8'h01], mem[mem_rd_addr[7:0]]};
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= mem_rd_req ? wait_cnt + 2'h1 : 2'h0;
      mem_rd_data <= ~mem_rd_data;
    end
  end
endmodule

/* File: verif/test_compat_mode_protection_checker.sv */
`timescale 1ns/100ps
`include "compat_defs.vh"

// ----------------------------------------
// bench
// ----------------------------------------
module test_compat_mode_protection_checker;
  reg         clk_sys, nrst, instr_valid, protected_mode, interrupt_return_instr_32bit, int_event, slow;
  reg         gate_is_interrupt, target_conforming, task_switch, got_f, exp_f;
  reg  [4:0]  instr_class;
  reg  [1:0]  prot_privilege, io_privilege_level, target_dpl;
  reg  [2:0]  io_size;
  reg  [7:0]  got_v, b;
  reg  [8:0]  ev;
  reg  [15:0] segment_value, io_port, target_selector, q;
  reg  [31:0] eff_offset, tss_base, tss_limit, flags_in, stacked_flags, off;
  reg  [31:0] task_flags_image, task_page_dir, seed;
  wire        mem_rd_req, mem_rd_ack, compat_mode_flag, check_done, fault, clear_tf, clear_if;
  wire [1:0]  current_privilege_level;
  wire [7:0]  fault_vector;
  wire [15:0] mem_rd_data, fault_error_code;
  wire [31:0] mem_rd_addr, push_flags_data, linear_addr, saved_flags, page_directory_base_reg;
  integer     n_errors, total_checks, i, j, k;

  compat_mode_protection_checker compat_mode_protection_checker_inst (.*);
  tss_memory_model tss_memory_model_inst (.clk_sys(clk_sys), .slow(slow),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // expected {fault, vector} of a class from privileged to interrupt return in compat mode
  function [8:0] expect_cls(input [4:0] c, input [1:0] pl);
    case (c)
      `CLS_PRIV:                        expect_cls = 9'h10D;
      `CLS_PROT_ONLY:                   expect_cls = 9'h106;
      `CLS_INT3, `CLS_INTO, `CLS_BOUND: expect_cls = 9'h000;
      default:                          expect_cls = (pl != 2'h3) ? 9'h10D : 9'h000;
    endcase
  endfunction

  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // issue one instruction and wait, bounded, for its answer
  task issue(input [4:0] cls);
    begin
      instr_class = cls;
      instr_valid = 1'b1;
      tick;
      instr_valid = 1'b0;
      k = 0;
      while (check_done !== 1'b1 && fault !== 1'b1 && k < 20) begin
        tick;
        k = k + 1;
      end
      got_f = fault;
      got_v = fault_vector & {8{fault}};
      check(k < 20, 1);
      tick;
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // hang guard
  initial begin
    #(50 * 5000);
    n_errors = n_errors + 1;
    report_and_stop;
  end

  initial begin
    seed = 32'hDB546DB3;
    n_errors = 0;
    total_checks = 0;
    {nrst, instr_valid, int_event, task_switch, slow, interrupt_return_instr_32bit} = 6'b000001;
    {gate_is_interrupt, target_conforming, target_dpl, target_selector} = 20'h00000;
    instr_class = `CLS_NONE;
    protected_mode = 1'b1;
    prot_privilege = 2'h1;
    io_privilege_level = 2'h3;
    {segment_value, io_port, io_size} = 35'h000000001;
    {eff_offset, flags_in, task_flags_image, task_page_dir} = 128'h0;
    tss_base = 32'h00000000;
    tss_limit = 32'h00000088;
    stacked_flags = 32'h00020000;
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1'b1;
    tick;
    check(current_privilege_level, 1);
    issue(`CLS_PRIV);
    check({got_f, got_v}, 9'h10D);
    issue(`CLS_INTERRUPT_RETURN_INSTR);
    check(compat_mode_flag, 0);
    protected_mode = 1'b0;
    issue(`CLS_PROT_ONLY);
    check({got_f, got_v}, 9'h106);
    protected_mode = 1'b1;
    prot_privilege = 2'h0;
    issue(`CLS_INTERRUPT_RETURN_INSTR);
    check(compat_mode_flag, 1);
    check(current_privilege_level, 3);
    // every class from privileged to interrupt return, random io level, random flag images
    for (i = 0; i < 44; i = i + 1) begin
      seed = lfsr(seed);
      io_privilege_level = seed[1:0];
      flags_in = seed;
      stacked_flags = ~seed;
      issue(i % 11 + 1);
      ev = expect_cls(instr_class, io_privilege_level);
      check({got_f, got_v}, ev);
      check(compat_mode_flag, 1);
      check(push_flags_data[17], 0);
    end
    // address formation around the 64 Kbyte edge
    for (i = 0; i < 30; i = i + 1) begin
      seed = lfsr(seed);
      segment_value = seed[31:16];
      eff_offset = (i < 2) ? 32'h0000FFFF + i : {15'h0, seed[16:0]};
      issue(`CLS_MEM);
      check(got_f, eff_offset > 32'h0000FFFF);
      if (!got_f)
        check(linear_addr, {12'h0, segment_value, 4'h0} + eff_offset);
    end
    eff_offset = 32'h00000000;
    // port accesses against the bitmap; io level 0 would deny all, but in compat mode only the bitmap decides
    io_privilege_level = 2'h0;
    for (i = 0; i < 40; i = i + 1) begin
      seed = lfsr(seed);
      slow = seed[9];
      io_size = 3'h1 << (seed[11:10] % 3);
      io_port = (i < 4) ? 16'd253 + i : seed[24:16] % 300;
      exp_f = 1'b0;
      for (j = 0; j < io_size; j = j + 1) begin
        q = io_port + j;
        off = {tss_memory_model_inst.mem[8'h67], tss_memory_model_inst.mem[8'h66]} + q[15:3];
        b = tss_memory_model_inst.mem[off[7:0]];
        if (off > tss_limit || b[q[2:0]])
          exp_f = 1'b1;
      end
      issue(`CLS_IO);
      check({got_f, got_v}, {exp_f, 8'h0D & {8{exp_f}}});
    end
    // task switch into compat mode, then leave through a gate
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      task_flags_image = 32'h00020000;
      task_page_dir = seed;
      task_switch = 1'b1;
      tick;
      task_switch = 1'b0;
      check(compat_mode_flag, 1);
      check(page_directory_base_reg, seed);
      gate_is_interrupt = seed[0];
      target_conforming = (i == 1);
      target_dpl = (i > 3) ? seed[3:2] : 2'h0;
      target_selector = seed[31:16];
      int_event = 1'b1;
      tick;
      int_event = 1'b0;
      check({compat_mode_flag, saved_flags[17], clear_tf, clear_if}, {3'b011, seed[0]});
      exp_f = target_conforming || target_dpl != 2'h0;
      check(fault, exp_f);
      if (exp_f)
        check(fault_error_code, target_selector);
      tick;
    end
    report_and_stop;
  end
endmodule
